// file: pwr_pkg.sv
package pwr_pkg;
   // Printed offsets are not all multiples of four, so they are register indices.
   localparam logic [15:0] P2_DATA_IDX   = 16'hf210;
   localparam logic [15:0] P2_CFGHI_IDX  = 16'hf212;
   localparam logic [15:0] P2_CFGLO_IDX  = 16'hf213;
   localparam logic [15:0] P2_FSEL_IDX   = 16'hf214;
   localparam logic [15:0] P3_DATA_IDX   = 16'hf218;
   localparam logic [15:0] P3_DIR_IDX    = 16'hf219;
   localparam logic [15:0] P3_CFGLO_IDX  = 16'hf21a;
   localparam logic [15:0] P3_CFGHI_IDX  = 16'hf21b;
   localparam logic [15:0] P3_FSELLO_IDX = 16'hf21c;
   localparam logic [15:0] P3_FSELHI_IDX = 16'hf21d;
   localparam int          ADDR_W        = 18;
   localparam int          PIN_BIT       = 4;
   localparam logic [7:0]  P3_IMPL_MASK  = 8'h3f;
   localparam logic [7:0]  P2_IMPL_MASK  = 8'h17;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [3:0] {
      PWR_P2D  = 4'h0,
      PWR_P2C1 = 4'h1,
      PWR_P2C0 = 4'h2,
      PWR_P2M  = 4'h3,
      PWR_P3D  = 4'h4,
      PWR_P3R  = 4'h5,
      PWR_P3C0 = 4'h6,
      PWR_P3C1 = 4'h7,
      PWR_P3M0 = 4'h8,
      PWR_P3M1 = 4'h9,
      PWR_NONE = 4'hf
   } pwr_sel_t;
   // Byte address to register select; shared by the read and write paths.
   function automatic pwr_sel_t pwr_decode(input logic [ADDR_W-1:0] a);
      logic [15:0] idx;
      idx = a[ADDR_W-1:2];
      if (a[1:0] != 2'h0) return PWR_NONE;
      case (idx)
         P2_DATA_IDX:   return PWR_P2D;
         P2_CFGHI_IDX:  return PWR_P2C1;
         P2_CFGLO_IDX:  return PWR_P2C0;
         P2_FSEL_IDX:   return PWR_P2M;
         P3_DATA_IDX:   return PWR_P3D;
         P3_DIR_IDX:    return PWR_P3R;
         P3_CFGLO_IDX:  return PWR_P3C0;
         P3_CFGHI_IDX:  return PWR_P3C1;
         P3_FSELLO_IDX: return PWR_P3M0;
         P3_FSELHI_IDX: return PWR_P3M1;
         default:       return PWR_NONE;
      endcase
   endfunction
endpackage

// file: pwr_pin_drive.sv
`timescale 1ns/1ps
module pwr_pin_drive
   import pwr_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic funcSel,
   input  wire logic cfgHi,
   input  wire logic cfgLo,
   input  wire logic dirIn,
   input  wire logic dataBit,
   input  wire logic pwmWave,
   output logic      pinOut,
   output logic      pinOeN,
   output logic      pwmActive
);
   logic driveOk;
   logic pinOut_r;
   logic pinOeN_r;
   assign driveOk = cfgHi && cfgLo && !dirIn;
   // The pin is registered so it cannot glitch while routing bits change.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinOut_r <= 1'b0;
         pinOeN_r <= 1'b1;
      end else begin
         pinOut_r <= funcSel ? pwmWave : dataBit;
         pinOeN_r <= !driveOk;
      end
   end
   assign pinOut    = pinOut_r;
   assign pinOeN    = pinOeN_r;
   assign pwmActive = funcSel && driveOk;
endmodule

// file: pwr_routing.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Port-3 pin 4 carries PWM when its high select is 1 and low 0.
// - Port-3 pin 4 drives push-pull when both config bits are 1, direction 0.
// - Port-3 pin 4 data bit is ignored while the PWM function is selected.
// - Port-2 pin 4 carries PWM when its function select bit is 1.
// - Port-2 pin 4 drives push-pull when both its config bits are 1.
// - Port-2 pin 4 data bit is ignored while the PWM function is selected.
module pwr_routing
   import pwr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              pulseWidthChannelZero,
   output logic                   port3Pin4Out,
   output logic                   port3Pin4OeN,
   output logic                   port2Pin4Out,
   output logic                   port2Pin4OeN,
   output logic [1:0]             pwmRouteStatus
);
   logic [7:0]        regFile_r [0:9];
   logic [ADDR_W-1:0] awAddr_r;
   logic              awHeld_r;
   logic [31:0]       wData_r;
   logic              wHeld_r;
   logic              bValid_r;
   logic [1:0]        bResp_r;
   logic              rValid_r;
   logic [31:0]       rData_r;
   logic [1:0]        rResp_r;
   logic              doWrite;
   pwr_sel_t          wSel;
   pwr_sel_t          rSel;
   logic              port3FuncSel;
   logic              port2FuncSel;
   logic              p3Active;
   logic              p2Active;

   // Write address and data are accepted independently, in either order.
   assign s_axi_awready = !awHeld_r && !bValid_r;
   assign s_axi_wready  = !wHeld_r && !bValid_r;
   assign doWrite       = awHeld_r && wHeld_r && !bValid_r;
   assign wSel          = pwr_decode(awAddr_r);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wHeld_r <= 1'b0;
         wData_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r <= 1'b1;
         // Only byte lane 0 holds register data, so only its strobe matters.
         wData_r <= {24'h000000, s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
      end else if (doWrite) begin
         wHeld_r <= 1'b0;
      end
   end

   // The lane 0 strobe of a held write is lost otherwise, so keep it.
   logic wLane0_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wLane0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wLane0_r <= s_axi_wstrb[0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bValid_r <= 1'b0;
         bResp_r  <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_r <= 1'b1;
         bResp_r  <= (wSel == PWR_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bValid_r && s_axi_bready) begin
         bValid_r <= 1'b0;
      end
   end
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp  = bResp_r;

   // Port-2 registers only implement bits 4, 2, 1, 0; port-3 bits 5 to 0.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 10; i++) begin
            regFile_r[i] <= REG_RESET;
         end
      end else if (doWrite && wLane0_r && wSel != PWR_NONE) begin
         if (wSel <= PWR_P2M) begin
            regFile_r[wSel] <= wData_r[7:0] & P2_IMPL_MASK;
         end else begin
            regFile_r[wSel] <= wData_r[7:0] & P3_IMPL_MASK;
         end
      end
   end

   assign s_axi_arready = !rValid_r;
   assign rSel          = pwr_decode(s_axi_araddr);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rValid_r <= 1'b0;
         rData_r  <= '0;
         rResp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_r <= 1'b1;
         if (rSel == PWR_NONE) begin
            rData_r <= '0;
            rResp_r <= RESP_SLVERR;
         end else begin
            rData_r <= {24'h000000, regFile_r[rSel]};
            rResp_r <= RESP_OKAY;
         end
      end else if (rValid_r && s_axi_rready) begin
         rValid_r <= 1'b0;
      end
   end
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata  = rData_r;
   assign s_axi_rresp  = rResp_r;

   // Tertiary function needs select pair 1,0; pair 1,1 is another function.
   assign port3FuncSel = regFile_r[PWR_P3M1][PIN_BIT] && !regFile_r[PWR_P3M0][PIN_BIT];
   assign port2FuncSel = regFile_r[PWR_P2M][PIN_BIT];

   pwr_pin_drive port3Drive (
      .clk       (clk),
      .rst       (rst),
      .funcSel   (port3FuncSel),
      .cfgHi     (regFile_r[PWR_P3C1][PIN_BIT]),
      .cfgLo     (regFile_r[PWR_P3C0][PIN_BIT]),
      .dirIn     (regFile_r[PWR_P3R][PIN_BIT]),
      .dataBit   (regFile_r[PWR_P3D][PIN_BIT]),
      .pwmWave   (pulseWidthChannelZero),
      .pinOut    (port3Pin4Out),
      .pinOeN    (port3Pin4OeN),
      .pwmActive (p3Active)
   );

   // Port 2 has no direction register, so its direction input is tied low.
   pwr_pin_drive port2Drive (
      .clk       (clk),
      .rst       (rst),
      .funcSel   (port2FuncSel),
      .cfgHi     (regFile_r[PWR_P2C1][PIN_BIT]),
      .cfgLo     (regFile_r[PWR_P2C0][PIN_BIT]),
      .dirIn     (1'b0),
      .dataBit   (regFile_r[PWR_P2D][PIN_BIT]),
      .pwmWave   (pulseWidthChannelZero),
      .pinOut    (port2Pin4Out),
      .pinOeN    (port2Pin4OeN),
      .pwmActive (p2Active)
   );

   logic [1:0] status_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= 2'h0;
      end else begin
         status_r <= {p2Active, p3Active};
      end
   end
   assign pwmRouteStatus = status_r;

   // Port 3 routing and drive.
   a_p3_route_pwm : assert property (@(posedge clk) disable iff (rst)
      port3FuncSel |=> port3Pin4Out == $past(pulseWidthChannelZero))
      else $error("port3 pin4 does not follow the PWM wave");
   // Select pair 1,1 belongs to another function, so the data bit must show.
   a_p3_sel_pair : assert property (@(posedge clk) disable iff (rst)
      (regFile_r[PWR_P3M1][PIN_BIT] && regFile_r[PWR_P3M0][PIN_BIT])
      |=> port3Pin4Out == $past(regFile_r[PWR_P3D][PIN_BIT]))
      else $error("port3 pin4 routed PWM with select pair 1,1");
   a_p3_drive_en : assert property (@(posedge clk) disable iff (rst)
      (regFile_r[PWR_P3C1][PIN_BIT] && regFile_r[PWR_P3C0][PIN_BIT] &&
       !regFile_r[PWR_P3R][PIN_BIT]) |=> !port3Pin4OeN)
      else $error("port3 pin4 not driven in push-pull setting");
   a_p3_drive_off : assert property (@(posedge clk) disable iff (rst)
      regFile_r[PWR_P3R][PIN_BIT] |=> port3Pin4OeN)
      else $error("port3 pin4 driven while set as input");
   a_p3_cfg_off : assert property (@(posedge clk) disable iff (rst)
      !(regFile_r[PWR_P3C1][PIN_BIT] && regFile_r[PWR_P3C0][PIN_BIT]) |=> port3Pin4OeN)
      else $error("port3 pin4 driven without both config bits");
   a_p3_status : assert property (@(posedge clk) disable iff (rst)
      (port3FuncSel && regFile_r[PWR_P3C1][PIN_BIT] && regFile_r[PWR_P3C0][PIN_BIT] &&
       !regFile_r[PWR_P3R][PIN_BIT]) |=> pwmRouteStatus[0])
      else $error("port3 PWM route not reported");
   a_p3_data_ignored : assert property (@(posedge clk) disable iff (rst)
      (port3FuncSel && regFile_r[PWR_P3D][PIN_BIT] && !pulseWidthChannelZero) |=> !port3Pin4Out)
      else $error("port3 data bit leaks onto PWM pin");

   // Port 2 routing and drive.
   a_p2_route_pwm : assert property (@(posedge clk) disable iff (rst)
      port2FuncSel |=> port2Pin4Out == $past(pulseWidthChannelZero))
      else $error("port2 pin4 does not follow the PWM wave");
   a_p2_sel_off : assert property (@(posedge clk) disable iff (rst)
      !port2FuncSel |=> port2Pin4Out == $past(regFile_r[PWR_P2D][PIN_BIT]))
      else $error("port2 pin4 shows PWM while its select is off");
   a_p2_sel_write : assert property (@(posedge clk) disable iff (rst)
      (awHeld_r && wHeld_r && !bValid_r && wLane0_r && wSel == PWR_P2M)
      |=> port2FuncSel == $past(wData_r[PIN_BIT]))
      else $error("port2 function select not taken from the write");
   a_p2_drive_en : assert property (@(posedge clk) disable iff (rst)
      (regFile_r[PWR_P2C1][PIN_BIT] && regFile_r[PWR_P2C0][PIN_BIT]) |=> !port2Pin4OeN)
      else $error("port2 pin4 not driven in push-pull setting");
   a_p2_cfg_off : assert property (@(posedge clk) disable iff (rst)
      !(regFile_r[PWR_P2C1][PIN_BIT] && regFile_r[PWR_P2C0][PIN_BIT]) |=> port2Pin4OeN)
      else $error("port2 pin4 driven without both config bits");
   a_p2_status : assert property (@(posedge clk) disable iff (rst)
      (port2FuncSel && regFile_r[PWR_P2C1][PIN_BIT] && regFile_r[PWR_P2C0][PIN_BIT])
      |=> pwmRouteStatus[1])
      else $error("port2 PWM route not reported");
   a_p2_data_ignored : assert property (@(posedge clk) disable iff (rst)
      (port2FuncSel && regFile_r[PWR_P2D][PIN_BIT] && !pulseWidthChannelZero) |=> !port2Pin4Out)
      else $error("port2 data bit leaks onto PWM pin");

   // Register contents.
   a_unimpl_zero : assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rSel != PWR_NONE) |=> s_axi_rdata[31:6] == 26'h0)
      else $error("unimplemented bits read as nonzero");
   a_p2_unimpl_zero : assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rSel != PWR_NONE && rSel <= PWR_P2M)
      |=> (s_axi_rdata[7:0] & ~P2_IMPL_MASK) == 8'h00)
      else $error("port2 unimplemented bits read as nonzero");
   // A write with lane 0 off must leave the port-3 high select and both function selects as they were.
   a_lane0_off : assert property (@(posedge clk) disable iff (rst)
      (awHeld_r && wHeld_r && !bValid_r && !wLane0_r)
      |=> $stable(regFile_r[PWR_P3M1]) && $stable(port3FuncSel) && $stable(port2FuncSel))
      else $error("register changed by a write with lane 0 off");

   // Bus steps used by the handshake checks below.
   sequence s_write_pair;
      awHeld_r && wHeld_r && !bValid_r;
   endsequence

   sequence s_resp_taken;
      s_axi_bvalid && s_axi_bready;
   endsequence

   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   sequence s_read_done;
      s_axi_rvalid && s_axi_rready;
   endsequence

   // Ready stays low while an answer waits, which keeps one transfer in flight.
   a_wr_answer : assert property (@(posedge clk) disable iff (rst)
      s_write_pair |=> s_axi_bvalid)
      else $error("write response missing after address and data");
   a_wr_unmapped : assert property (@(posedge clk) disable iff (rst)
      (awHeld_r && wHeld_r && !bValid_r && wSel == PWR_NONE) |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_wr_busy : assert property (@(posedge clk) disable iff (rst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while a response waits");
   a_wr_clear : assert property (@(posedge clk) disable iff (rst)
      s_resp_taken |=> !s_axi_bvalid)
      else $error("write response stays after it was taken");
   a_rd_answer : assert property (@(posedge clk) disable iff (rst)
      s_read_taken |=> s_axi_rvalid)
      else $error("read data missing after address");
   a_rd_unmapped : assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && rSel == PWR_NONE)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_rd_busy : assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data waits");
   a_rd_clear : assert property (@(posedge clk) disable iff (rst)
      s_read_done |=> !s_axi_rvalid)
      else $error("read data stays after it was taken");
endmodule

// file: pwr_pin_sink.sv
`timescale 1ns/1ps
// Circuit that receives one routed pin.
module pwr_pin_sink (
   input  wire logic clk,
   input  wire logic pinOut,
   input  wire logic pinOeN,
   output logic      pinLevel
);
   logic lastLevel_r = 1'b0;
   always_ff @(posedge clk) begin
      if (!pinOeN) begin
         lastLevel_r <= pinOut;
      end
   end
   // The wire has no pull, so a released pin shows the inverse of its last driven level.
   assign pinLevel = pinOeN ? ~lastLevel_r : pinOut;
endmodule

// file: test_pwr_routing.sv
`timescale 1ns/1ps
module test_pwr_routing;
   import pwr_pkg::*;
   logic              clk = 1'b0, rst = 1'b1, pwm = 1'b0;
   logic [ADDR_W-1:0] awAddr = '0, arAddr = '0;
   logic [31:0]       wData = '0, rData;
   logic [3:0]        wStrb = '0;
   logic              awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0;
   logic              rReady = 1'b0, awReady, wReady, bValid, arReady, rValid;
   logic [1:0]        bResp, rResp, status;
   logic              p3Out, p3OeN, p2Out, p2OeN, lvl3, lvl2;
   logic              lane0 = 1'b1;
   int                errors = 0, cmp_count = 0;
   logic [7:0]        sh [10];
   logic [15:0]       idxs [10] = '{P2_DATA_IDX, P2_CFGHI_IDX, P2_CFGLO_IDX, P2_FSEL_IDX,
      P3_DATA_IDX, P3_DIR_IDX, P3_CFGLO_IDX, P3_CFGHI_IDX, P3_FSELLO_IDX, P3_FSELHI_IDX};
   logic [7:0]        msk [10] = '{8'h17, 8'h17, 8'h17, 8'h17, 8'h3f, 8'h3f, 8'h3f, 8'h3f,
      8'h3f, 8'h3f};

   pwr_routing i_pwr_routing (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .pulseWidthChannelZero(pwm), .port3Pin4Out(p3Out), .port3Pin4OeN(p3OeN),
      .port2Pin4Out(p2Out), .port2Pin4OeN(p2OeN), .pwmRouteStatus(status));
   pwr_pin_sink i_pwr_pin_sink_p3 (.clk(clk), .pinOut(p3Out), .pinOeN(p3OeN), .pinLevel(lvl3));
   pwr_pin_sink i_pwr_pin_sink_p2 (.clk(clk), .pinOut(p2Out), .pinOeN(p2OeN), .pinLevel(lvl2));

   always #12.5 clk = ~clk;

   task close_out;
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Level the pin must show: the wave when routed, else the port data bit.
   function automatic logic exp_level(input logic sel, input logic wave, input logic dat);
      return sel ? wave : dat;
   endfunction

   // A wait that used up its bound ends the run at once.
   task bound(input int n);
      if (n >= 40) begin
         errors++;
         $display("Error at %0t: no answer from the bus", $time);
         close_out;
      end
   endtask

   task wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic aw, w, awT, wT;
      @(posedge clk);
      awAddr <= {idx, 2'b00};
      wData <= {24'($urandom), d};
      wStrb <= {3'($urandom), lane0};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      while ((aw || w) && n < 40) begin
         @(negedge clk);
         awT = aw && awReady;
         wT = w && wReady;
         @(posedge clk);
         if (awT) begin
            awValid <= 1'b0;
            aw = 1'b0;
         end
         if (wT) begin
            wValid <= 1'b0;
            w = 1'b0;
         end
         n++;
      end
      bound(n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (bValid !== 1'b1 && n < 40);
      bound(n);
      chk(bResp, er);
      @(posedge clk);
      bReady <= 1'b0;
   endtask

   task rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      arAddr <= {idx, 2'b00};
      arValid <= 1'b1;
      rReady <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (arReady !== 1'b1 && n < 40);
      bound(n);
      @(posedge clk);
      arValid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rValid !== 1'b1 && n < 40);
      bound(n);
      chk(rData, {24'h0, d});
      chk(rResp, er);
      @(posedge clk);
      rReady <= 1'b0;
   endtask

   task run_pins(input int cyc);
      logic p, m3, m2, o3, o2;
      m3 = sh[9][4] & ~sh[8][4];
      o3 = ~(sh[7][4] & sh[6][4] & ~sh[5][4]);
      m2 = sh[3][4];
      o2 = ~(sh[1][4] & sh[2][4]);
      repeat (cyc) begin
         @(posedge clk);
         p = pwm;
         pwm <= 1'($urandom);
         @(negedge clk);
         chk(p3Out, exp_level(m3, p, sh[4][4]));
         chk(p3OeN, o3);
         chk(p2Out, exp_level(m2, p, sh[0][4]));
         chk(p2OeN, o2);
         chk(status, {m2 & ~o2, m3 & ~o3});
         if (!o3) chk(lvl3, exp_level(m3, p, sh[4][4]));
         if (!o2) chk(lvl2, exp_level(m2, p, sh[0][4]));
      end
   endtask

   initial begin
      int k, j;
      logic [9:0] b;
      logic [7:0] d;
      k = $urandom(61);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 10; k++) rd(idxs[k], REG_RESET, RESP_OKAY);
      rd(16'hf211, 8'h00, RESP_SLVERR);
      wr(16'hf211, 8'hff, RESP_SLVERR);
      // First the documented setting, then one select bit and the direction bit off it.
      for (k = 0; k < 24; k++) begin
         b = (k == 0) ? 10'b1011011111 : (k == 1) ? 10'b1111011111 :
             (k == 2) ? 10'b1011111111 : 10'($urandom);
         for (j = 0; j < 10; j++) begin
            d = 8'($urandom);
            d[4] = b[j];
            wr(idxs[j], d, RESP_OKAY);
            sh[j] = d & msk[j];
         end
         for (j = 0; j < 10; j++) rd(idxs[j], sh[j], RESP_OKAY);
         run_pins(8);
      end
      // A write with lane 0 strobe off must not store anything.
      lane0 = 1'b0;
      wr(idxs[9], ~sh[9], RESP_OKAY);
      lane0 = 1'b1;
      rd(idxs[9], sh[9], RESP_OKAY);
      run_pins(4);
      // A second reset in mid-run brings every register and pin back to idle.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (k = 0; k < 10; k++) begin
         sh[k] = REG_RESET;
         rd(idxs[k], REG_RESET, RESP_OKAY);
      end
      run_pins(4);
      close_out;
   end
endmodule
